// *** logic/hvp_params.svh ***
// Constants of the coefficient coder and macro block packer
`ifndef HVP_PARAMS_SVH
`define HVP_PARAMS_SVH

// Register offsets and fields
`define HVP_CTRL_OFS      8'h00
`define HVP_STAT_OFS      8'h04
`define HVP_OVF_OFS       8'h08
`define HVP_CTRL_STA_F    3:0
`define HVP_CTRL_QNO_F    7:4
`define HVP_CTRL_EN_B     8

// Macro block and segment geometry
`define HVP_LAST_BYTE     7'd76
`define HVP_SEG_LAST_MB   3'd4
`define HVP_LAST_BLK      3'd7
`define HVP_HDR_BITS      10'd8
`define HVP_BIG_BITS      10'd80
`define HVP_SMALL_BITS    10'd64
`define HVP_BIG_AREAS     3'd6

// Code words
`define HVP_HDR_WORD_LEN  5'd12
`define HVP_MODE_RSVD     1'b1
`define HVP_EOB_CODE      16'h0006
`define HVP_EOB_LEN       5'd4
`define HVP_ESC_AMP_PFX   7'h7F
`define HVP_ESC_AMP_MIN   8'd23
`define HVP_ESC_AMP_LEN   5'd15
`define HVP_ESC_RUN_PFX   7'h7E
`define HVP_ESC_RUN_LEN   5'd13
`define HVP_ESC_RUN_MIN   6'd6
`define HVP_Z01_CODE      16'h07CE
`define HVP_Z01_LEN       5'd11
`define HVP_Z25_CODE      16'h0FAC
`define HVP_Z25_LEN       5'd12
`define HVP_Z25_MIN       6'd2
`define HVP_WORD_BITS     5'd16

`endif

// *** logic/hvp_pkg.sv ***
// Types of the coefficient coder and macro block packer
package hvp_pkg;

    typedef enum logic [1:0] {
        HVP_SYM_HDR,
        HVP_SYM_AC,
        HVP_SYM_END,
        HVP_SYM_NONE
    } hvp_kind_t;

    typedef struct packed {
        hvp_kind_t   kind;
        logic [8:0]  dc;
        logic        mode;
        logic [1:0]  cls;
        logic [5:0]  run;
        logic [7:0]  amp;
        logic        sign;
    } hvp_sym_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } hvp_apb_req_t;

    typedef struct packed {
        logic [7:0]  data;
        logic        valid;
        logic        last;
        logic        seg_last;
    } hvp_mb_out_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  blk;
        logic [10:0] bits;
    } hvp_ovf_t;

    typedef enum logic [1:0] {
        HVP_IDLE,
        HVP_SHIFT,
        HVP_OUT
    } hvp_state_t;

    typedef struct packed {
        hvp_state_t       st;
        logic [15:0]      sh;
        logic [4:0]       left;
        logic             pend;
        logic [7:0]       pend_amp;
        logic             pend_sign;
        logic             end_blk;
        logic [2:0]       blk;
        logic [10:0]      bitpos;
        logic [10:0]      ovf;
        logic [76:0][7:0] mb;
        logic [2:0]       mbcnt;
        logic [6:0]       oidx;
        logic             sym_ready;
        hvp_mb_out_t      mbo;
        hvp_ovf_t         ovfo;
        logic [3:0]       status;
        logic [3:0]       qidx;
        logic             en;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } hvp_regs_t;

endpackage

// *** logic/hvp_packer.sv ***
// Coefficient coder and compressed macro block packer with APB control
//
// Functional notes
// - Sign bit follows every nonzero amplitude word
// - Block terminator is 0110, no sign
// - Zero runs 0 and 1: eleven-bit words
// - Zero runs 2 to 5: twelve-bit words
// - Zero runs 6 to 61: escape plus run
// - Run-0 amplitudes 23 to 255: escape, amplitude, sign
// - Five macro blocks of 77 bytes per segment
// - Each macro block carries four-bit status nibble
// - Status nibble restricted to defined codes
// - Status 0111 marks inserted error code
// - Status 1111 marks unlocated error
// - Four-bit quantization index per macro block
// - Header word: DC, mode bit, class
// - Mode bit forced to 1 after first block
// - Luma, red areas 80 bits; blue 64
// - Block words fill its area MSB first
// - Sign is 0 positive, 1 negative
// - Missing pair splits into zero run, amplitude
// - Terminator directly follows last code word
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "hvp_params.svh"

module hvp_packer (
    input  wire logic                  CLOCK,     // System clock
    input  wire logic                  RESET_N,   // Asynchronous reset
    input  wire hvp_pkg::hvp_apb_req_t APB_REQ,   // APB request
    output logic [31:0]                PRDATA,    // APB read data
    output logic                       PREADY,    // APB ready
    output logic                       PSLVERR,   // APB error
    input  wire hvp_pkg::hvp_sym_t     SYM_IN,    // Quantizer symbol
    input  wire logic                  SYM_VALID, // Symbol valid
    output logic                       SYM_READY, // Symbol taken when high
    output hvp_pkg::hvp_mb_out_t       MB_OUT,    // Packed macro block bytes
    input  wire logic                  MB_READY,  // Byte consumer ready
    output hvp_pkg::hvp_ovf_t          OVF_OUT    // Per-block overflow report
);

    hvp_pkg::hvp_regs_t s_r;
    hvp_pkg::hvp_regs_t s_nxt;
    logic [21:0]        w;
    logic [9:0]         abs_bit;
    logic [8:0]         ac_hdr;

    //--------------------------------------------------------------
    // Code tables
    //--------------------------------------------------------------
    function automatic logic [15:0] align(input logic [15:0] c, input logic [4:0] l);
        align = 16'(c << (`HVP_WORD_BITS - l));
    endfunction

    // Zero amplitude run word, returns {len, code}
    function automatic logic [20:0] zrun_word(input logic [5:0] r);
        if (r < `HVP_Z25_MIN)
            zrun_word = {`HVP_Z01_LEN, `HVP_Z01_CODE | 16'(r[0])};
        else if (r < `HVP_ESC_RUN_MIN)
            zrun_word = {`HVP_Z25_LEN, `HVP_Z25_CODE | 16'(2'(r - `HVP_Z25_MIN))};
        else
            zrun_word = {`HVP_ESC_RUN_LEN, 3'h0, `HVP_ESC_RUN_PFX, r};
    endfunction

    // Nonzero amplitude word without sign, returns {found, len, code}
    function automatic logic [21:0] ac_word(input logic [5:0] r, input logic [7:0] a);
        logic [21:0] t;
        t = '0;
        if (r == 6'h00 && a >= `HVP_ESC_AMP_MIN) begin
            t = {1'b1, `HVP_ESC_AMP_LEN, 1'b0, `HVP_ESC_AMP_PFX, a};
        end else begin
            case ({r, a})
                14'h0001: t = {1'b1, 5'h02, 16'h0000};
                14'h0002: t = {1'b1, 5'h03, 16'h0002};
                14'h0003: t = {1'b1, 5'h04, 16'h0008};
                14'h0004: t = {1'b1, 5'h04, 16'h0009};
                14'h0005: t = {1'b1, 5'h05, 16'h0016};
                14'h0006: t = {1'b1, 5'h05, 16'h0017};
                14'h0007: t = {1'b1, 5'h06, 16'h0032};
                14'h0008: t = {1'b1, 5'h06, 16'h0033};
                14'h0009: t = {1'b1, 5'h07, 16'h006D};
                14'h000A: t = {1'b1, 5'h07, 16'h006E};
                14'h000B: t = {1'b1, 5'h07, 16'h006F};
                14'h000C: t = {1'b1, 5'h08, 16'h00EA};
                14'h000D: t = {1'b1, 5'h08, 16'h00EB};
                14'h000E: t = {1'b1, 5'h08, 16'h00EC};
                14'h000F: t = {1'b1, 5'h08, 16'h00ED};
                14'h0010: t = {1'b1, 5'h08, 16'h00EE};
                14'h0011: t = {1'b1, 5'h08, 16'h00EF};
                14'h0012: t = {1'b1, 5'h09, 16'h01EB};
                14'h0013: t = {1'b1, 5'h09, 16'h01EC};
                14'h0014: t = {1'b1, 5'h09, 16'h01ED};
                14'h0015: t = {1'b1, 5'h09, 16'h01EE};
                14'h0016: t = {1'b1, 5'h09, 16'h01EF};
                14'h0101: t = {1'b1, 5'h04, 16'h0007};
                14'h0102: t = {1'b1, 5'h05, 16'h0015};
                14'h0103: t = {1'b1, 5'h07, 16'h006B};
                14'h0104: t = {1'b1, 5'h07, 16'h006C};
                14'h0105: t = {1'b1, 5'h08, 16'h00E7};
                14'h0106: t = {1'b1, 5'h08, 16'h00E8};
                14'h0107: t = {1'b1, 5'h08, 16'h00E9};
                14'h0108: t = {1'b1, 5'h09, 16'h01EA};
                14'h0109: t = {1'b1, 5'h0A, 16'h03E4};
                14'h010A: t = {1'b1, 5'h0A, 16'h03E5};
                14'h010B: t = {1'b1, 5'h0A, 16'h03E6};
                14'h010C: t = {1'b1, 5'h0B, 16'h07D3};
                14'h010D: t = {1'b1, 5'h0B, 16'h07D4};
                14'h010E: t = {1'b1, 5'h0B, 16'h07D5};
                14'h0201: t = {1'b1, 5'h05, 16'h0014};
                14'h0202: t = {1'b1, 5'h07, 16'h006A};
                14'h0203: t = {1'b1, 5'h08, 16'h00E6};
                14'h0204: t = {1'b1, 5'h09, 16'h01E8};
                14'h0205: t = {1'b1, 5'h09, 16'h01E9};
                14'h0206: t = {1'b1, 5'h0A, 16'h03E3};
                14'h0301: t = {1'b1, 5'h06, 16'h0030};
                14'h0302: t = {1'b1, 5'h08, 16'h00E4};
                14'h0303: t = {1'b1, 5'h09, 16'h01E6};
                14'h0304: t = {1'b1, 5'h0A, 16'h03E1};
                14'h0305: t = {1'b1, 5'h0A, 16'h03E2};
                14'h0306: t = {1'b1, 5'h0B, 16'h07D2};
                14'h0401: t = {1'b1, 5'h06, 16'h0031};
                14'h0402: t = {1'b1, 5'h08, 16'h00E5};
                14'h0403: t = {1'b1, 5'h09, 16'h01E7};
                14'h0404: t = {1'b1, 5'h0B, 16'h07D1};
                14'h0501: t = {1'b1, 5'h07, 16'h0068};
                14'h0502: t = {1'b1, 5'h09, 16'h01E4};
                14'h0503: t = {1'b1, 5'h0A, 16'h03E0};
                14'h0601: t = {1'b1, 5'h07, 16'h0069};
                14'h0602: t = {1'b1, 5'h09, 16'h01E5};
                14'h0603: t = {1'b1, 5'h0B, 16'h07D0};
                14'h0701: t = {1'b1, 5'h08, 16'h00E0};
                14'h0801: t = {1'b1, 5'h08, 16'h00E1};
                14'h0901: t = {1'b1, 5'h08, 16'h00E2};
                14'h0A01: t = {1'b1, 5'h08, 16'h00E3};
                14'h0B01: t = {1'b1, 5'h09, 16'h01E0};
                14'h0C01: t = {1'b1, 5'h09, 16'h01E1};
                14'h0D01: t = {1'b1, 5'h09, 16'h01E2};
                14'h0E01: t = {1'b1, 5'h09, 16'h01E3};
                default:  t = '0;
            endcase
        end
        ac_word = t;
    endfunction

    // Appends the sign bit below the code word
    function automatic logic [20:0] signed_word(input logic [20:0] u, input logic s);
        signed_word = {5'(u[20:16] + 5'h01), u[14:0], s};
    endfunction

    function automatic logic status_ok(input logic [3:0] v);
        case (v)
            4'h0, 4'h2, 4'h4, 4'h6, 4'h7: status_ok = 1'b1;
            4'hA, 4'hC, 4'hE, 4'hF:       status_ok = 1'b1;
            default:                      status_ok = 1'b0;
        endcase
    endfunction

    // Areas Y0..Y3, CR0, CR1 of 80 bits, then CB0, CB1 of 64 bits
    function automatic logic [9:0] area_start(input logic [2:0] b);
        if (b < `HVP_BIG_AREAS)
            area_start = `HVP_HDR_BITS + 10'(b) * `HVP_BIG_BITS;
        else
            area_start = `HVP_HDR_BITS + 10'(`HVP_BIG_AREAS) * `HVP_BIG_BITS
                       + 10'(3'(b - `HVP_BIG_AREAS)) * `HVP_SMALL_BITS;
    endfunction

    function automatic logic [10:0] area_len(input logic [2:0] b);
        area_len = (b < `HVP_BIG_AREAS) ? 11'(`HVP_BIG_BITS) : 11'(`HVP_SMALL_BITS);
    endfunction

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        w = '0;
        abs_bit = '0;
        ac_hdr = '0;
        s_nxt.ovfo.valid = 1'b0;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;

        // APB setup: answer is ready in the access cycle
        if (APB_REQ.psel && !APB_REQ.penable) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = '0;
            case (APB_REQ.paddr)
                `HVP_CTRL_OFS: begin
                    s_nxt.prdata = 32'({s_r.en, s_r.qidx, s_r.status});
                    s_nxt.pslverr = APB_REQ.pwrite
                                  && !status_ok(APB_REQ.pwdata[`HVP_CTRL_STA_F]);
                end
                `HVP_STAT_OFS: begin
                    s_nxt.prdata = 32'({s_r.st != hvp_pkg::HVP_IDLE, s_r.blk, s_r.mbcnt});
                    s_nxt.pslverr = APB_REQ.pwrite;
                end
                `HVP_OVF_OFS: begin
                    s_nxt.prdata = 32'({s_r.ovfo.blk, s_r.ovfo.bits});
                    s_nxt.pslverr = APB_REQ.pwrite;
                end
                default: s_nxt.pslverr = 1'b1;
            endcase
        end
        if (APB_REQ.psel && APB_REQ.penable && s_r.pready && !s_r.pslverr
            && APB_REQ.pwrite && APB_REQ.paddr == `HVP_CTRL_OFS) begin
            s_nxt.status = APB_REQ.pwdata[`HVP_CTRL_STA_F];
            s_nxt.qidx = APB_REQ.pwdata[`HVP_CTRL_QNO_F];
            s_nxt.en = APB_REQ.pwdata[`HVP_CTRL_EN_B];
        end

        case (s_r.st)
            hvp_pkg::HVP_IDLE: begin
                if (SYM_VALID && s_r.sym_ready) begin
                    s_nxt.st = hvp_pkg::HVP_SHIFT;
                    s_nxt.pend = 1'b0;
                    s_nxt.end_blk = 1'b0;
                    case (SYM_IN.kind)
                        hvp_pkg::HVP_SYM_HDR: begin
                            ac_hdr = SYM_IN.dc;
                            s_nxt.bitpos = '0;
                            s_nxt.ovf = '0;
                            s_nxt.sh = align({4'h0, ac_hdr,
                                (s_r.blk == 3'h0) ? SYM_IN.mode : `HVP_MODE_RSVD,
                                SYM_IN.cls}, `HVP_HDR_WORD_LEN);
                            s_nxt.left = `HVP_HDR_WORD_LEN;
                        end
                        hvp_pkg::HVP_SYM_AC: begin
                            w = ac_word(SYM_IN.run, SYM_IN.amp);
                            if (SYM_IN.amp == 8'h00) begin
                                w = {1'b1, zrun_word(SYM_IN.run)};
                            end else if (w[21]) begin
                                w = {1'b1, signed_word(w[20:0], SYM_IN.sign)};
                            end else begin
                                w = {1'b1, zrun_word(6'(SYM_IN.run - 6'h01))};
                                s_nxt.pend = 1'b1;
                                s_nxt.pend_amp = SYM_IN.amp;
                                s_nxt.pend_sign = SYM_IN.sign;
                            end
                            s_nxt.sh = align(w[15:0], w[20:16]);
                            s_nxt.left = w[20:16];
                        end
                        hvp_pkg::HVP_SYM_END: begin
                            s_nxt.sh = align(`HVP_EOB_CODE, `HVP_EOB_LEN);
                            s_nxt.left = `HVP_EOB_LEN;
                            s_nxt.end_blk = 1'b1;
                        end
                        default: s_nxt.st = hvp_pkg::HVP_IDLE;
                    endcase
                end
            end
            hvp_pkg::HVP_SHIFT: begin
                // One bit per cycle into the block's area, excess counted
                if (s_r.bitpos < area_len(s_r.blk)) begin
                    abs_bit = area_start(s_r.blk) + s_r.bitpos[9:0];
                    s_nxt.mb[abs_bit[9:3]][~abs_bit[2:0]] = s_r.sh[15];
                end else begin
                    s_nxt.ovf = 11'(s_r.ovf + 11'h001);
                end
                s_nxt.bitpos = 11'(s_r.bitpos + 11'h001);
                s_nxt.sh = 16'(s_r.sh << 1);
                s_nxt.left = 5'(s_r.left - 5'h01);
                if (s_r.left == 5'h01) begin
                    if (s_r.pend) begin
                        w = ac_word(6'h00, s_r.pend_amp);
                        w = {1'b1, signed_word(w[20:0], s_r.pend_sign)};
                        s_nxt.sh = align(w[15:0], w[20:16]);
                        s_nxt.left = w[20:16];
                        s_nxt.pend = 1'b0;
                    end else if (s_r.end_blk) begin
                        s_nxt.ovfo.valid = 1'b1;
                        s_nxt.ovfo.blk = s_r.blk;
                        s_nxt.ovfo.bits = s_nxt.ovf;
                        s_nxt.blk = 3'(s_r.blk + 3'h1);
                        s_nxt.end_blk = 1'b0;
                        if (s_r.blk == `HVP_LAST_BLK) begin
                            s_nxt.st = hvp_pkg::HVP_OUT;
                            s_nxt.mb[0] = {s_r.status, s_r.qidx};
                            s_nxt.mbo.data = {s_r.status, s_r.qidx};
                            s_nxt.mbo.valid = 1'b1;
                            s_nxt.mbo.last = 1'b0;
                            s_nxt.mbo.seg_last = 1'b0;
                            s_nxt.oidx = '0;
                        end else begin
                            s_nxt.st = hvp_pkg::HVP_IDLE;
                        end
                    end else begin
                        s_nxt.st = hvp_pkg::HVP_IDLE;
                    end
                end
            end
            hvp_pkg::HVP_OUT: begin
                if (MB_READY && s_r.mbo.valid) begin
                    if (s_r.oidx == `HVP_LAST_BYTE) begin
                        s_nxt.mbo = '0;
                        s_nxt.mb = '0;
                        s_nxt.blk = '0;
                        s_nxt.st = hvp_pkg::HVP_IDLE;
                        s_nxt.mbcnt = (s_r.mbcnt == `HVP_SEG_LAST_MB) ? 3'h0
                                    : 3'(s_r.mbcnt + 3'h1);
                    end else begin
                        s_nxt.oidx = 7'(s_r.oidx + 7'h01);
                        s_nxt.mbo.data = s_r.mb[s_nxt.oidx];
                        s_nxt.mbo.last = (s_nxt.oidx == `HVP_LAST_BYTE);
                        s_nxt.mbo.seg_last = (s_nxt.oidx == `HVP_LAST_BYTE)
                                           && (s_r.mbcnt == `HVP_SEG_LAST_MB);
                    end
                end
            end
            default: s_nxt.st = hvp_pkg::HVP_IDLE;
        endcase

        s_nxt.sym_ready = (s_nxt.st == hvp_pkg::HVP_IDLE) && s_nxt.en;
    end

    //--------------------------------------------------------------
    // State register
    //--------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign PRDATA = s_r.prdata;
    assign PREADY = s_r.pready;
    assign PSLVERR = s_r.pslverr;
    assign SYM_READY = s_r.sym_ready;
    assign MB_OUT = s_r.mbo;
    assign OVF_OUT = s_r.ovfo;

endmodule

// *** tb/hvp_packer_monitor.sv ***
// Port protocol checker of the macro block packer
`timescale 1ns/10ps
module hvp_packer_monitor (
    input wire logic                  CLOCK,     // Clock
    input wire logic                  RESET_N,   // Reset
    input wire hvp_pkg::hvp_apb_req_t APB_REQ,   // APB request
    input wire logic [31:0]           PRDATA,    // Read data
    input wire logic                  PREADY,    // Ready
    input wire logic                  PSLVERR,   // Error
    input wire hvp_pkg::hvp_sym_t     SYM_IN,    // Symbol
    input wire logic                  SYM_VALID, // Symbol valid
    input wire logic                  SYM_READY, // Symbol ready
    input wire hvp_pkg::hvp_mb_out_t  MB_OUT,    // Byte stream
    input wire logic                  MB_READY,  // Byte ready
    input wire hvp_pkg::hvp_ovf_t     OVF_OUT    // Overflow report
);
    logic [6:0] n_byte_r;
    logic       sym_take;
    assign sym_take = SYM_VALID && SYM_READY;
    // Counts bytes accepted in the current macro block
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) n_byte_r <= 7'h00;
        else if (MB_OUT.valid && MB_READY) n_byte_r <= MB_OUT.last ? 7'h00 : n_byte_r + 7'h01;
    end
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    chk_apb_ready_slot: assert property (APB_REQ.psel && !APB_REQ.penable |=> PREADY)
        else $error("ready missing after setup");
    chk_err_needs_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    chk_hdr_busy: assert property (
        sym_take && SYM_IN.kind == hvp_pkg::HVP_SYM_HDR |=> !SYM_READY [*8])
        else $error("header word too short");
    chk_ac_busy: assert property (
        sym_take && SYM_IN.kind == hvp_pkg::HVP_SYM_AC |=> !SYM_READY [*3])
        else $error("code word too short");
    chk_end_busy: assert property (
        sym_take && SYM_IN.kind == hvp_pkg::HVP_SYM_END |=> !SYM_READY [*4])
        else $error("terminator too short");
    chk_byte_hold: assert property (MB_OUT.valid && !MB_READY |=> MB_OUT.valid && $stable(MB_OUT.data))
        else $error("byte dropped while stalled");
    chk_seg_last: assert property (MB_OUT.seg_last |-> MB_OUT.last && MB_OUT.valid)
        else $error("segment end off a block end");
    chk_last_count: assert property (MB_OUT.valid && MB_OUT.last |-> n_byte_r == 7'h4C)
        else $error("macro block length wrong");
    chk_ovf_pulse: assert property (OVF_OUT.valid |=> !OVF_OUT.valid)
        else $error("overflow report too long");
    chk_out_no_sym: assert property (MB_OUT.valid |-> !SYM_READY)
        else $error("symbols taken during output");
    cov_seg_end: cover property (MB_OUT.seg_last && MB_READY);
    cov_refused: cover property (PSLVERR);
    cov_overflow: cover property (OVF_OUT.valid && OVF_OUT.bits != 11'h000);
endmodule

// *** tb/hvp_mb_sink.sv ***
// Byte consumer model that stalls inside macro blocks
`timescale 1ns/10ps
module hvp_mb_sink (
    input  wire logic                 clock,    // Clock
    input  wire logic                 reset_n,  // Reset
    input  wire hvp_pkg::hvp_mb_out_t mb_out,   // Offered bytes
    output logic                      mb_ready  // Byte taken when high
);
    logic [2:0] cnt_r;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) cnt_r <= 3'h0;
        else if (mb_out.valid) cnt_r <= cnt_r + 3'h1;
    end
    // Two stall cycles in every eight offered
    assign mb_ready = (cnt_r != 3'h5) && (cnt_r != 3'h6);
endmodule

// *** tb/testbench.sv ***
// Self-checking bench of the macro block packer
`timescale 1ns/10ps
module testbench;
    logic                  CLOCK, RESET_N, SYM_VALID, MB_READY, PREADY, PSLVERR, SYM_READY;
    logic [31:0]           PRDATA, lfsr;
    hvp_pkg::hvp_apb_req_t APB_REQ;
    hvp_pkg::hvp_sym_t     SYM_IN;
    hvp_pkg::hvp_mb_out_t  MB_OUT;
    hvp_pkg::hvp_ovf_t     OVF_OUT;
    int                    n_mismatch, comparisons, pos, lim, ovf, c, s;
    logic [615:0]          em;
    logic [9:0]            mbq[$];
    logic [13:0]           ovq[$];
    logic [3:0]            codes[9] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'hA, 4'hC, 4'hE, 4'hF};
    logic [3:0]            bad[7]   = '{4'h1, 4'h3, 4'h5, 4'h8, 4'h9, 4'hB, 4'hD};
    logic [15:0]           vc[8] = '{16'h0000, 16'h0002, 16'h0007, 16'h07CE,
                                     16'h0FAD, 16'h1F94, 16'h7FC8, 16'h00ED};
    int                    vl[8] = '{2, 3, 4, 11, 12, 13, 15, 8};
    logic [5:0]            vr[8] = '{6'h00, 6'h00, 6'h01, 6'h00, 6'h03, 6'h14, 6'h00, 6'h01};
    logic [7:0]            va[8] = '{8'h01, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'hC8, 8'h0F};

    hvp_packer u_dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .APB_REQ(APB_REQ), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .SYM_IN(SYM_IN), .SYM_VALID(SYM_VALID),
        .SYM_READY(SYM_READY), .MB_OUT(MB_OUT), .MB_READY(MB_READY), .OVF_OUT(OVF_OUT));
    hvp_mb_sink u_sink (.clock(CLOCK), .reset_n(RESET_N), .mb_out(MB_OUT), .mb_ready(MB_READY));

    initial begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic e, input logic [31:0] m, input logic [31:0] x);
        APB_REQ <= '{1'b1, 1'b0, w, a, d};
        @(posedge CLOCK);
        APB_REQ.penable <= 1'b1;
        @(posedge CLOCK);
        while (PREADY !== 1'b1) @(posedge CLOCK);
        check("pslverr", {31'h0, PSLVERR}, {31'h0, e});
        if (!w && !e) check("prdata", PRDATA & m, x);
        APB_REQ <= '0;
        @(posedge CLOCK);
    endtask
    // Appends a code word to the expected block, counting bits past the area
    task automatic put(input logic [15:0] cw, input int l);
        for (int i = l - 1; i >= 0; i--) begin
            if (pos < lim) em[615 - pos] = cw[i];
            else ovf++;
            pos++;
        end
    endtask
    task automatic sym(input hvp_pkg::hvp_kind_t k, input logic [5:0] r, input logic [7:0] a);
        SYM_IN <= '{k, lfsr[8:0], lfsr[9], lfsr[11:10], r, a, lfsr[12]};
        SYM_VALID <= 1'b1;
        @(posedge CLOCK);
        while (SYM_READY !== 1'b1) @(posedge CLOCK);
        SYM_VALID <= 1'b0;
        @(posedge CLOCK);
    endtask

    always @(posedge CLOCK) begin
        if (MB_OUT.valid === 1'b1 && MB_READY === 1'b1)
            check("mb byte", {22'h0, MB_OUT.data, MB_OUT.last, MB_OUT.seg_last},
                  {22'h0, mbq.pop_front()});
        if (OVF_OUT.valid === 1'b1)
            check("overflow", {18'h0, OVF_OUT.blk, OVF_OUT.bits}, {18'h0, ovq.pop_front()});
    end
    initial begin
        repeat (30000) @(posedge CLOCK);
        n_mismatch++;
        report_and_stop();
    end
    // ----------------------------------------
    // Register checks, then five macro blocks
    // ----------------------------------------
    initial begin
        APB_REQ = '0;
        SYM_IN = '0;
        SYM_VALID = 1'b0;
        RESET_N = 1'b0;
        lfsr = 32'hD1BB;
        repeat (10) @(posedge CLOCK);
        RESET_N <= 1'b1;
        apb(1'b0, 8'h00, 32'h0, 1'b0, 32'hFFFFFFFF, 32'h0);
        apb(1'b0, 8'h04, 32'h0, 1'b0, 32'h0000007F, 32'h0);
        apb(1'b0, 8'h0C, 32'h0, 1'b1, 32'h0, 32'h0);
        apb(1'b1, 8'h04, 32'h1, 1'b1, 32'h0, 32'h0);
        foreach (bad[i]) apb(1'b1, 8'h00, {23'h0, 9'h150 | bad[i]}, 1'b1, 32'h0, 32'h0);
        apb(1'b0, 8'h00, 32'h0, 1'b0, 32'h000001FF, 32'h0);
        foreach (codes[i]) begin
            apb(1'b1, 8'h00, {24'h1, i[3:0], codes[i]}, 1'b0, 32'h0, 32'h0);
            apb(1'b0, 8'h00, 32'h0, 1'b0, 32'h000001FF, {24'h1, i[3:0], codes[i]});
        end
        for (int m = 0; m < 5; m++) begin
            lfsr = lfsr_next(lfsr);
            apb(1'b1, 8'h00, {24'h1, lfsr[3:0], codes[2 * m]}, 1'b0, 32'h0, 32'h0);
            em = '0;
            em[615:608] = {codes[2 * m], lfsr[3:0]};
            if (m == 0) sym(hvp_pkg::HVP_SYM_NONE, 6'h00, 8'h00);
            for (int b = 0; b < 8; b++) begin
                c = (b + m) % 8;
                pos = 8 + ((b < 6) ? 80 * b : 480 + 64 * (b - 6));
                lim = pos + ((b < 6) ? 80 : 64);
                ovf = 0;
                lfsr = lfsr_next(lfsr);
                put({4'h0, lfsr[8:0], (b == 0) ? lfsr[9] : 1'b1, lfsr[11:10]}, 12);
                sym(hvp_pkg::HVP_SYM_HDR, 6'h00, 8'h00);
                for (int r = 0; r < ((b == 7) ? 4 : 1); r++) begin
                    lfsr = lfsr_next(lfsr);
                    s = (va[c] != 8'h00);
                    if (c == 7) put(16'h07CE, 11);
                    if (s == 1) put({vc[c][14:0], lfsr[12]}, vl[c] + 1);
                    else put(vc[c], vl[c]);
                    sym(hvp_pkg::HVP_SYM_AC, vr[c], va[c]);
                end
                put(16'h0006, 4);
                ovq.push_back({b[2:0], ovf[10:0]});
                if (b == 7)
                    for (int i = 0; i < 77; i++)
                        mbq.push_back({em[615 - 8 * i -: 8], i == 76, i == 76 && m == 4});
                sym(hvp_pkg::HVP_SYM_END, 6'h00, 8'h00);
            end
            while (mbq.size() != 0) @(posedge CLOCK);
        end
        check("ovf left", ovq.size(), 32'h0);
        report_and_stop();
    end
endmodule

bind hvp_packer hvp_packer_monitor u_mon (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .APB_REQ(APB_REQ), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SYM_IN(SYM_IN), .SYM_VALID(SYM_VALID), .SYM_READY(SYM_READY), .MB_OUT(MB_OUT),
    .MB_READY(MB_READY), .OVF_OUT(OVF_OUT));
